/* shared/ncou_consts.vh */
/*
 * Constants for the NAND command sequencer (host side).
 * Assumes a 50 MHz sys_clk and a byte-wide NAND device on the pins.
 */
// Function
// [R1] Device returns one byte per read strobe, column pointer advancing each strobe.
// [R2] Spare-area read uses same strobe timing, pointer within bytes 512 to 527.
// [R3] Once in read mode, successive pages stream without new address.
// [R4] Main reads give columns 0..527 per page; spare read gives spare only.
// [R5] At last column of last page, byte 527 repeats on each strobe.
// [R6] After status command, status byte is driven on each read strobe.
// [R7] Status: bit0 fail, bits1-5 zero, bit6 ready, bit7 not protected.
// [R8] Host trusts pass/fail bit only when the same byte shows ready.
// [R9] Host sends program setup, address, data, then execute; device programs.
// [R10] Erase: setup, block address, confirm directly after; device erases.
// [R11] Reset command aborts any operation and device goes waiting.
// [R12] After ID command and one address, maker then device byte are read.
// [R13] Power-up: chip select high, write protect asserted until released.
// [R14] Host waits about 200 us after power-up before any access.
// [R15] Host issues only defined command codes.
// [R16] While busy, host issues only status read or reset.
// [R17] After program setup, only execute or reset may follow.
// [R18] Host programs pages of a block in ascending order.
// [R19] With shared ready/busy, host uses status read per device.
// [R20] Device latches command on rising write strobe with command latch high.
// [R21] Address is three cycles, column first, top bit of third low.
// [R22] Read command picks pointer region: 0-255, 256-511, 512-527.
// [R23] Ready/busy is low during program, erase and array read.
// [R24] After reset the device is ready with pointer at first region.
`ifndef NCOU_CONSTS_VH
`define NCOU_CONSTS_VH

// Command codes
`define NCOU_CMD_READ_A    8'h00
`define NCOU_CMD_READ_B    8'h01
`define NCOU_CMD_READ_C    8'h50
`define NCOU_CMD_PROG_SET  8'h80
`define NCOU_CMD_PROG_EXE  8'h10
`define NCOU_CMD_ERASE_SET 8'h60
`define NCOU_CMD_ERASE_GO  8'hd0
`define NCOU_CMD_STATUS    8'h70
`define NCOU_CMD_ID        8'h90
`define NCOU_CMD_RESET     8'hff

// Software opcodes in the control register
`define NCOU_OP_READ   3'h0
`define NCOU_OP_PROG   3'h1
`define NCOU_OP_ERASE  3'h2
`define NCOU_OP_STATUS 3'h3
`define NCOU_OP_ID     3'h4
`define NCOU_OP_RESET  3'h5
`define NCOU_OP_RDBYTE 3'h6
`define NCOU_OP_WRBYTE 3'h7

// Register addresses
`define NCOU_ADDR_CTRL   4'h0
`define NCOU_ADDR_ADDR   4'h1
`define NCOU_ADDR_WDATA  4'h2
`define NCOU_ADDR_STAT   4'h3
`define NCOU_ADDR_RDATA  4'h4
`define NCOU_ADDR_PINS   4'h5

// Control register fields
`define NCOU_CTRL_OP_LO   0
`define NCOU_CTRL_OP_HI   2
`define NCOU_CTRL_RMODE_LO 4
`define NCOU_CTRL_RMODE_HI 5

// Device status byte fields
`define NCOU_SB_FAIL   0
`define NCOU_SB_READY  6
`define NCOU_SB_UNPROT 7

// Address layout
`define NCOU_PAGE_W   15
`define NCOU_COL_W    8
`define NCOU_PAGE_LO_HI 7
`define NCOU_PAGE_HI_HI 14

// Timing: strobe phase is this many sys_clk cycles (40 ns pulses)
`define NCOU_CLK_NS       20
`define NCOU_PHASE_NS     40
`define NCOU_PHASE_CYC    (((`NCOU_PHASE_NS) + (`NCOU_CLK_NS) - 1) / (`NCOU_CLK_NS))
// Power-up wait in microseconds and cycles
`define NCOU_PWR_US       200
`define NCOU_PWR_CYC      ((`NCOU_PWR_US) * 1000 / (`NCOU_CLK_NS))
`define NCOU_CNT_W        16
`define NCOU_ADDR_CYCLES  2'h3

`endif

/* rtl/ncou_host.v */
/*
 * Host controller that drives a byte-wide NAND device over its pins.
 * Software issues operations through a small register port; the block
 * sequences command, address and data cycles and watches ready/busy.
 * Assumes device pins are synchronous to sys_clk; one operation at a time.
 */
`include "ncou_consts.vh"

module ncou_host #(
	parameter PWR_WAIT = `NCOU_PWR_CYC
) (
	// Clock and reset
	input  wire        sys_clk,
	input  wire        reset,
	// Register port
	input  wire [3:0]  reg_addr,
	input  wire [31:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [31:0] reg_rdata,
	// Device pins
	output reg         chip_en_n,
	output reg         cmd_latch,
	output reg         addr_latch,
	output reg         write_strobe_n,
	output reg         output_strobe_n,
	output reg         write_prot_n,
	input  wire        ready_busy_n,
	input  wire [7:0]  io_in,
	output reg  [7:0]  io_out,
	output reg         io_oe
);

	localparam S_PWR   = 4'h0;
	localparam S_IDLE  = 4'h1;
	localparam S_CMD   = 4'h2;
	localparam S_ADDR  = 4'h3;
	localparam S_DATA  = 4'h4;
	localparam S_CMD2  = 4'h5;
	localparam S_BUSY  = 4'h6;
	localparam S_RDB   = 4'h7;
	localparam S_WAITB = 4'h8;

	reg [3:0]                state_reg;
	reg [`NCOU_CNT_W-1:0]    cnt_reg;
	reg                      phase_reg;
	reg [1:0]                acnt_reg;
	reg [2:0]                op_reg;
	reg [1:0]                rmode_reg;
	reg [7:0]                col_reg;
	reg [`NCOU_PAGE_W-1:0]   page_reg;
	reg [7:0]                wdata_reg;
	reg [7:0]                rdata_reg;
	reg [7:0]                cmd2_reg;
	reg                      cmd2_en_reg;
	reg                      sb_ready_reg;
	reg                      sb_fail_reg;
	reg                      sb_unprot_reg;
	reg                      sb_valid_reg;
	reg                      done_reg;
	reg                      rvalid_reg;
	reg                      wp_rel_reg;

	wire busy_flag = (state_reg != S_IDLE);
	wire start     = reg_wr && (reg_addr == `NCOU_ADDR_CTRL) && !busy_flag;
	wire [2:0] new_op = reg_wdata[`NCOU_CTRL_OP_HI:`NCOU_CTRL_OP_LO];
	wire busy_refuse = !ready_busy_n && new_op != `NCOU_OP_STATUS && new_op != `NCOU_OP_RESET;
	wire prog_refuse = cmd2_en_reg && new_op != `NCOU_OP_PROG &&
		new_op != `NCOU_OP_WRBYTE && new_op != `NCOU_OP_RESET; // Execute pending [R17]
	wire phase_end = (cnt_reg == `NCOU_PHASE_CYC - 1);

	// Read command code follows the region chosen by software [R22]
	reg [7:0] read_cmd;
	always @* begin
		case (rmode_reg)
			2'h1:    read_cmd = `NCOU_CMD_READ_B;
			2'h2:    read_cmd = `NCOU_CMD_READ_C; // Spare region only [R2]
			default: read_cmd = `NCOU_CMD_READ_A;
		endcase
	end

	// First command byte per op; only defined codes ever reach the pins [R15]
	reg [7:0] first_cmd;
	always @* begin
		case (op_reg)
			`NCOU_OP_PROG:   first_cmd = `NCOU_CMD_PROG_SET;  // [R9]
			`NCOU_OP_ERASE:  first_cmd = `NCOU_CMD_ERASE_SET; // [R10]
			`NCOU_OP_STATUS: first_cmd = `NCOU_CMD_STATUS;    // [R6]
			`NCOU_OP_ID:     first_cmd = `NCOU_CMD_ID;        // [R12]
			`NCOU_OP_RESET:  first_cmd = `NCOU_CMD_RESET;     // [R11]
			default:         first_cmd = read_cmd;
		endcase
	end

	// Address byte for the current cycle, column first except for erase, which sends page bytes only [R21]
	reg [7:0] addr_byte;
	always @* begin
		case (acnt_reg)
			2'h0:    addr_byte = (op_reg == `NCOU_OP_ERASE) ? page_reg[7:0] : col_reg;
			2'h1:    addr_byte = (op_reg == `NCOU_OP_ERASE) ?
				{1'b0, page_reg[`NCOU_PAGE_HI_HI:8]} : page_reg[7:0];
			default: addr_byte = {1'b0, page_reg[`NCOU_PAGE_HI_HI:8]}; // Top bit low
		endcase
	end

	// Address cycles per op: ID takes one, erase two page bytes, read and program three
	reg [1:0] addr_last;
	always @* begin
		case (op_reg)
			`NCOU_OP_ID:    addr_last = 2'h0;
			`NCOU_OP_ERASE: addr_last = 2'h1;
			default:        addr_last = `NCOU_ADDR_CYCLES - 2'h1;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer
	always @(posedge sys_clk) begin
		if (reset) begin
			state_reg       <= S_PWR;
			cnt_reg         <= {`NCOU_CNT_W{1'b0}};
			phase_reg       <= 1'b0;
			acnt_reg        <= 2'h0;
			op_reg          <= `NCOU_OP_READ;
			cmd2_reg        <= 8'h00;
			cmd2_en_reg     <= 1'b0;
			chip_en_n       <= 1'b1; // Held high through power-up [R13]
			cmd_latch       <= 1'b0;
			addr_latch      <= 1'b0;
			write_strobe_n  <= 1'b1;
			output_strobe_n <= 1'b1;
			write_prot_n    <= 1'b0; // Protected until software releases [R13]
			io_out          <= 8'h00;
			io_oe           <= 1'b0;
			rdata_reg       <= 8'h00;
			done_reg        <= 1'b0;
			rvalid_reg      <= 1'b0;
			sb_ready_reg    <= 1'b0;
			sb_fail_reg     <= 1'b0;
			sb_unprot_reg   <= 1'b0;
			sb_valid_reg    <= 1'b0;
		end else begin
			write_prot_n <= wp_rel_reg;
			if (start)
				done_reg <= 1'b0;
			case (state_reg)
				// Wait before the first access [R14]
				S_PWR: begin
					if (cnt_reg == PWR_WAIT[`NCOU_CNT_W-1:0] - 1'b1) begin
						cnt_reg   <= {`NCOU_CNT_W{1'b0}};
						state_reg <= S_IDLE;
					end else
						cnt_reg <= cnt_reg + 1'b1;
				end
				S_IDLE: begin
					if (start) begin
						op_reg    <= new_op;
						cnt_reg   <= {`NCOU_CNT_W{1'b0}};
						phase_reg <= 1'b0;
						acnt_reg  <= 2'h0;
						chip_en_n <= 1'b0;
						rvalid_reg <= 1'b0; // Fresh flag per op
						// Busy device takes only status or reset [R16]
						if (busy_refuse || prog_refuse)
							state_reg <= S_WAITB; // Refused, no strobes [R17]
						else if (cmd2_en_reg && new_op == `NCOU_OP_PROG)
							state_reg <= S_CMD2; // Execute after the data bytes [R9]
						else if (new_op == `NCOU_OP_RDBYTE)
							state_reg <= S_RDB;
						else if (new_op == `NCOU_OP_WRBYTE)
							state_reg <= S_DATA;
						else
							state_reg <= S_CMD;
						// Setup arms the execute, the next program op sends it [R17]
						if (!busy_refuse && new_op == `NCOU_OP_PROG)
							cmd2_en_reg <= !cmd2_en_reg;
						else if (new_op == `NCOU_OP_RESET)
							cmd2_en_reg <= 1'b0;
						cmd2_reg <= (new_op == `NCOU_OP_ERASE) ?
							`NCOU_CMD_ERASE_GO : `NCOU_CMD_PROG_EXE;
					end
				end
				S_WAITB: begin
					if (ready_busy_n)
						state_reg <= S_IDLE;
					chip_en_n <= 1'b1;
				end
				// Command cycle: latch high, strobe low then rising edge [R20]
				S_CMD, S_CMD2: begin
					cmd_latch <= 1'b1;
					io_oe     <= 1'b1;
					io_out    <= (state_reg == S_CMD) ? first_cmd : cmd2_reg;
					write_strobe_n <= phase_reg;
					if (phase_end) begin
						cnt_reg   <= {`NCOU_CNT_W{1'b0}};
						phase_reg <= ~phase_reg;
						if (phase_reg) begin
							cmd_latch <= 1'b0;
							io_oe     <= 1'b0;
							phase_reg <= 1'b0;
							if (state_reg == S_CMD2)
								state_reg <= S_BUSY; // Auto op begins [R9] [R10]
							else if (op_reg == `NCOU_OP_STATUS ||
								op_reg == `NCOU_OP_RESET)
								state_reg <= (op_reg == `NCOU_OP_RESET) ?
									S_BUSY : S_IDLE;
							else
								state_reg <= S_ADDR;
						end
					end else
						cnt_reg <= cnt_reg + 1'b1;
				end
				// Address cycles
				S_ADDR: begin
					addr_latch     <= 1'b1;
					io_oe          <= 1'b1;
					io_out         <= addr_byte; // [R21]
					write_strobe_n <= phase_reg;
					if (phase_end) begin
						cnt_reg   <= {`NCOU_CNT_W{1'b0}};
						phase_reg <= ~phase_reg;
						if (phase_reg) begin
							if (acnt_reg == addr_last) begin
								addr_latch <= 1'b0;
								io_oe      <= 1'b0;
								acnt_reg   <= 2'h0;
								if (op_reg == `NCOU_OP_ERASE)
									state_reg <= S_CMD2; // Confirm directly [R10]
								else if (op_reg == `NCOU_OP_READ)
									state_reg <= S_BUSY; // Array fetch [R23]
								else
									state_reg <= S_IDLE; // ID or program data
							end else
								acnt_reg <= acnt_reg + 2'h1;
						end
					end else
						cnt_reg <= cnt_reg + 1'b1;
				end
				// One data byte out; program execute is a separate op
				S_DATA: begin
					io_oe          <= 1'b1;
					io_out         <= wdata_reg;
					write_strobe_n <= phase_reg;
					if (phase_end) begin
						cnt_reg   <= {`NCOU_CNT_W{1'b0}};
						phase_reg <= ~phase_reg;
						if (phase_reg) begin
							io_oe     <= 1'b0;
							phase_reg <= 1'b0;
							state_reg <= S_IDLE;
						end
					end else
						cnt_reg <= cnt_reg + 1'b1;
				end
				// One read strobe; device advances its own column [R1] [R3] [R5]
				S_RDB: begin
					output_strobe_n <= phase_reg;
					if (phase_end) begin
						cnt_reg   <= {`NCOU_CNT_W{1'b0}};
						phase_reg <= ~phase_reg;
						if (!phase_reg) begin
							rdata_reg  <= io_in;
							rvalid_reg <= 1'b1;
							// Status fields captured from each read [R7]
							sb_ready_reg  <= io_in[`NCOU_SB_READY];
							sb_fail_reg   <= io_in[`NCOU_SB_FAIL];
							sb_unprot_reg <= io_in[`NCOU_SB_UNPROT];
							// Fail bit means nothing while busy [R8]
							sb_valid_reg  <= io_in[`NCOU_SB_READY];
						end else begin
							phase_reg <= 1'b0;
							state_reg <= S_IDLE;
						end
					end else
						cnt_reg <= cnt_reg + 1'b1;
				end
				// Wait for ready/busy release; shared line needs status per device [R19]
				S_BUSY: begin
					if (phase_end) begin
						if (ready_busy_n) begin
							state_reg <= S_IDLE;
							done_reg  <= 1'b1;
							// Next read goes to the first region after reset [R24]
						end
					end else
						cnt_reg <= cnt_reg + 1'b1;
				end
				default: state_reg <= S_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Software-written registers; execute issued on a program op's second step
	always @(posedge sys_clk) begin
		if (reset) begin
			rmode_reg  <= 2'h0;
			col_reg    <= 8'h00;
			page_reg   <= {`NCOU_PAGE_W{1'b0}};
			wdata_reg  <= 8'h00;
			wp_rel_reg <= 1'b0;
		end else if (reg_wr) begin
			if (reg_addr == `NCOU_ADDR_CTRL && !busy_flag)
				rmode_reg <= reg_wdata[`NCOU_CTRL_RMODE_HI:`NCOU_CTRL_RMODE_LO];
			if (reg_addr == `NCOU_ADDR_ADDR) begin
				col_reg  <= reg_wdata[7:0];
				page_reg <= reg_wdata[8+`NCOU_PAGE_W-1:8]; // Ascending order is software's [R18]
			end
			if (reg_addr == `NCOU_ADDR_WDATA)
				wdata_reg <= reg_wdata[7:0];
			if (reg_addr == `NCOU_ADDR_PINS)
				wp_rel_reg <= reg_wdata[0];
		end else if (state_reg == S_BUSY && op_reg == `NCOU_OP_RESET && ready_busy_n)
			rmode_reg <= 2'h0; // [R24]
	end

	////////////////////////////////////////////////////////////////////////
	// Read port, data one cycle after the strobe
	always @(posedge sys_clk) begin
		if (reset)
			reg_rdata <= 32'h0000_0000;
		else if (reg_rd) begin
			case (reg_addr)
				`NCOU_ADDR_CTRL:  reg_rdata <= {26'h0, rmode_reg, 1'b0, op_reg};
				`NCOU_ADDR_ADDR:  reg_rdata <= {9'h0, page_reg, col_reg};
				`NCOU_ADDR_WDATA: reg_rdata <= {24'h0, wdata_reg};
				`NCOU_ADDR_STAT:  reg_rdata <= {24'h0, sb_valid_reg, sb_unprot_reg,
					sb_ready_reg, sb_fail_reg, ready_busy_n, rvalid_reg, done_reg,
					busy_flag};
				`NCOU_ADDR_RDATA: reg_rdata <= {24'h0, rdata_reg};
				`NCOU_ADDR_PINS:  reg_rdata <= {31'h0, wp_rel_reg};
				default:          reg_rdata <= 32'h0000_0000;
			endcase
		end
	end


endmodule // ncou_host

/* tb/ncou_dev_model.sv */
/* Behavioural model of the byte-wide NAND device on the host pins.
   Assumes pins change just after sys_clk edges, so it samples them there. */
module ncou_dev_model #(
	parameter [7:0] MAKER_ID  = 8'h3c, // Arbitrary identity value
	parameter [7:0] DEVICE_ID = 8'hc3, // Arbitrary identity value
	parameter       BUSY_CYC  = 24
) (
	// Host pins
	input  wire        sys_clk,
	input  wire        chip_en_n,
	input  wire        cmd_latch,
	input  wire        addr_latch,
	input  wire        write_strobe_n,
	input  wire        output_strobe_n,
	input  wire        write_prot_n,
	input  wire  [7:0] io_out,
	// Device outputs
	output logic [7:0] io_in,
	output logic       ready_busy_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        ws_q = 1'b1, os_q = 1'b1, idx = 1'b0;
	logic [7:0]  cmd = 8'hff, last = 8'h00, prog_data = 8'h00, cur;
	logic [1:0]  acnt = 2'h0, region = 2'h0, mode = 2'h0;
	logic [9:0]  col = 10'h000, busy = 10'h000;
	logic [14:0] page = 15'h0000;
	wire         wr_edge = !ws_q && write_strobe_n && !chip_en_n;
	////////////////////////////////////////
	// Array content is a fixed pattern so the bench can predict it
	function automatic [7:0] pat(input [14:0] p, input [9:0] c);
		pat = c[7:0] ^ p[7:0] ^ {6'h00, c[9:8]};
	endfunction
	// Pulled up when released; a floating bus shows the inverse of the last byte
	assign ready_busy_n = (busy == 10'h000);
	assign io_in = output_strobe_n ? ~last : cur;
	always_comb begin
		case (mode)
		2'h1: cur = {write_prot_n, busy == 10'h000, 6'h00};
		2'h2: cur = idx ? DEVICE_ID : MAKER_ID;
		default: cur = pat(page, col);
		endcase
	end
	// Latch on rising write strobe, advance on rising read strobe
	always @(posedge sys_clk) begin
		ws_q <= write_strobe_n;
		os_q <= output_strobe_n;
		if (busy != 10'h000)
			busy <= busy - 10'h001;
		if (wr_edge && cmd_latch) begin
			cmd  <= io_out;
			acnt <= 2'h0;
			case (io_out)
			8'h00, 8'h01, 8'h50: begin
				mode   <= 2'h0;
				region <= {io_out[4], io_out[0]};
			end
			8'h70: mode <= 2'h1;
			8'h90: begin
				mode <= 2'h2;
				idx  <= 1'b0;
			end
			8'h10: if (cmd == 8'h80) busy <= BUSY_CYC; // Other commands skip it
			8'hd0: if (cmd == 8'h60) busy <= BUSY_CYC;
			8'hff: begin // Abort, short discharge, pointer home
				busy   <= 10'h004;
				mode   <= 2'h0;
				region <= 2'h0;
			end
			default: ;
			endcase
		end else if (wr_edge && addr_latch) begin
			acnt <= acnt + 2'h1;
			if (acnt == 2'h0 && cmd != 8'h60)
				col <= region[1] ? {6'h20, io_out[3:0]} : {1'b0, region[0], io_out};
			else if (acnt == ((cmd == 8'h60) ? 2'h0 : 2'h1))
				page[7:0] <= io_out;
			else begin
				page[14:8] <= io_out[6:0];
				if (cmd == 8'h00 || cmd == 8'h01 || cmd == 8'h50)
					busy <= BUSY_CYC; // Array to register
			end
		end else if (wr_edge)
			prog_data <= io_out;
		if (!os_q && output_strobe_n) begin
			last <= cur;
			idx  <= 1'b1;
			if (mode == 2'h0 && col != 10'd527)
				col <= col + 10'd1;
			else if (mode == 2'h0 && page != 15'h7fff) begin
				page <= page + 15'd1;
				col  <= region[1] ? 10'd512 : 10'd0;
			end // Last column of last page repeats
		end
	end
endmodule // ncou_dev_model

/* tb/ncou_host_chk.sv */
/* Assertions on the NAND host controller's pins and register port.
   Assumes it is bound to ncou_host with the same PWR_WAIT. */
module ncou_host_chk #(
	parameter PWR_WAIT = 8
) (
	input wire        sys_clk,
	input wire        reset,
	input wire [3:0]  reg_addr,
	input wire        reg_rd,
	input wire [31:0] reg_rdata,
	input wire        chip_en_n,
	input wire        cmd_latch,
	input wire        addr_latch,
	input wire        write_strobe_n,
	input wire        output_strobe_n,
	input wire        write_prot_n,
	input wire        ready_busy_n,
	input wire [7:0]  io_out,
	input wire        io_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0]  last_cmd;
	logic [1:0]  acnt;
	logic [15:0] pcnt;
	logic        ws_q;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	////////////////////////////////////////
	// Last command, address cycles since it, and power-up wait count
	always_ff @(posedge sys_clk) begin
		ws_q <= write_strobe_n;
		if (reset) begin
			last_cmd <= 8'h00;
			acnt     <= 2'h0;
			pcnt     <= 16'h0000;
		end else begin
			if (pcnt < PWR_WAIT)
				pcnt <= pcnt + 16'h0001;
			if (!ws_q && write_strobe_n && cmd_latch) begin
				last_cmd <= io_out;
				acnt     <= 2'h0;
			end else if (!ws_q && write_strobe_n && addr_latch && acnt != 2'h3)
				acnt <= acnt + 2'h1;
		end
	end
	property p_rst_pins; $fell(reset) |-> chip_en_n && !write_prot_n && write_strobe_n; endproperty
	a_rst_pins: assert property (p_rst_pins) else $error("pins active after reset");
	property p_pwr; pcnt < PWR_WAIT |-> write_strobe_n && output_strobe_n; endproperty
	a_pwr: assert property (p_pwr) else $error("access during power-up wait");
	property p_cmd_set;
		$rose(write_strobe_n) && cmd_latch |->
			io_out inside {8'h00, 8'h01, 8'h50, 8'h80, 8'h10, 8'h60, 8'hd0, 8'h70, 8'h90, 8'hff};
	endproperty
	a_cmd_set: assert property (p_cmd_set) else $error("undefined command code");
	property p_busy_cmd;
		$rose(write_strobe_n) && cmd_latch && !ready_busy_n |-> io_out inside {8'h70, 8'hff};
	endproperty
	a_busy_cmd: assert property (p_busy_cmd) else $error("command while busy");
	property p_after_prog;
		$rose(write_strobe_n) && cmd_latch && last_cmd == 8'h80 |-> io_out inside {8'h10, 8'hff};
	endproperty
	a_after_prog: assert property (p_after_prog) else $error("bad command after 80");
	property p_erase; $rose(write_strobe_n) && cmd_latch && io_out == 8'hd0 |-> last_cmd == 8'h60;
	endproperty
	a_erase: assert property (p_erase) else $error("confirm without erase setup");
	property p_addr_top; $rose(write_strobe_n) && addr_latch && acnt == 2'h2 |-> !io_out[7];
	endproperty
	a_addr_top: assert property (p_addr_top) else $error("third address top bit set");
	property p_latch_hold;
		// Bus and strobe fall together, so hold is checked from the second low cycle
		!write_strobe_n && !$past(write_strobe_n) |->
			$stable(cmd_latch) && $stable(addr_latch) && $stable(io_out) && io_oe;
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("bus moved under strobe");
	property p_no_clash;
		!output_strobe_n |-> write_strobe_n && !io_oe && !cmd_latch && !addr_latch;
	endproperty
	a_no_clash: assert property (p_no_clash) else $error("drive during read strobe");
	property p_unmapped; reg_rd && reg_addr > 4'h5 |=> reg_rdata == 32'h0; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule // ncou_host_chk

/* tb/ncou_host_tb.sv */
/* Self-checking bench: host controller, device model and bound checker.
   Assumes the register map and op codes of the controller's hand-over. */
module ncou_host_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam PWR_WAIT = 8;
	localparam [7:0] MAKER = 8'h3c, DEVICE = 8'hc3; // Arbitrary identity values
	logic        sys_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [3:0]  reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0, d;
	wire  [31:0] reg_rdata;
	wire         chip_en_n, cmd_latch, addr_latch, write_strobe_n, output_strobe_n;
	wire         write_prot_n, io_oe, ready_busy_n;
	wire  [7:0]  io_in, io_out;
	int          error_cnt = 0, num_checks = 0;
	always #10 sys_clk = ~sys_clk;
	ncou_host #(.PWR_WAIT(PWR_WAIT)) dut (.sys_clk, .reset, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .chip_en_n, .cmd_latch, .addr_latch, .write_strobe_n,
		.output_strobe_n, .write_prot_n, .ready_busy_n, .io_in, .io_out, .io_oe);
	ncou_dev_model #(.MAKER_ID(MAKER), .DEVICE_ID(DEVICE)) dev (.sys_clk, .chip_en_n,
		.cmd_latch, .addr_latch, .write_strobe_n, .output_strobe_n, .write_prot_n, .io_out,
		.io_in, .ready_busy_n);
	////////////////////////////////////////
	// Expected array byte, worked out independently of the model
	function automatic [7:0] px(input [14:0] p, input [9:0] c);
		px = {c[7:0] ^ p[7:0]} ^ {6'h00, c[9:8]};
	endfunction
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic results;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Register bus: one-cycle strobes, read data in the following cycle
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
	endtask
	// Bounded poll of the busy bit; running out ends the run
	task automatic wait_idle;
		logic [31:0] s;
		for (int i = 0; i < 500; i++) begin
			rd(4'h3, s);
			if (s[0] === 1'b0)
				return;
		end
		error_cnt++;
		$display("MISMATCH busy wait expected 0 seen 1");
		results();
	endtask
	task automatic op(input logic [2:0] o, input logic [1:0] rm);
		wr(4'h0, {26'h0, rm, 1'b0, o});
		wait_idle();
	endtask
	task automatic read_at(input logic [14:0] p, input logic [7:0] c, input logic [1:0] rm);
		wr(4'h1, {9'h0, p, c});
		op(3'h0, rm);
	endtask
	task automatic rdbyte(input logic [7:0] e);
		op(3'h6, 2'h0);
		rd(4'h4, d);
		cmp("read byte", {24'h0, e}, {24'h0, d[7:0]});
		rd(4'h3, d);
		cmp("read valid", 32'h1, {31'h0, d[2]});
	endtask
	// Main sequence
	initial begin
		repeat (10) @(posedge sys_clk);
		cmp("ce in reset", 32'h1, {31'h0, chip_en_n});
		cmp("wp in reset", 32'h0, {31'h0, write_prot_n});
		reset <= 1'b0;
		rd(4'h3, d);
		cmp("power wait busy", 32'h1, {31'h0, d[0]});
		wait_idle();
		wr(4'h5, 32'h1);
		repeat (2) @(posedge sys_clk);
		cmp("wp released", 32'h1, {31'h0, write_prot_n});
		rd(4'hc, d);
		cmp("unmapped read", 32'h0, d);
		op(3'h3, 2'h0);
		rdbyte(8'hc0);
		rd(4'h3, d);
		cmp("status fields", 32'he, {28'h0, d[7:4]});
		read_at(15'h0003, 8'hfe, 2'h0);
		rdbyte(px(15'h0003, 10'd254));
		rdbyte(px(15'h0003, 10'd255));
		rdbyte(px(15'h0003, 10'd256));
		read_at(15'h0005, 8'h10, 2'h1);
		rdbyte(px(15'h0005, 10'd272));
		read_at(15'h0005, 8'h0e, 2'h2);
		rdbyte(px(15'h0005, 10'd526));
		rdbyte(px(15'h0005, 10'd527));
		rdbyte(px(15'h0006, 10'd512));
		read_at(15'h7fff, 8'h0f, 2'h2);
		repeat (3) rdbyte(px(15'h7fff, 10'd527));
		op(3'h4, 2'h0);
		rdbyte(MAKER);
		rdbyte(DEVICE);
		wr(4'h1, {9'h0, 15'h0020, 8'h00});
		op(3'h2, 2'h0);
		rd(4'h3, d);
		cmp("erase done", 32'h1, {31'h0, d[1]});
		op(3'h3, 2'h0);
		rdbyte(8'hc0);
		rd(4'h3, d);
		cmp("erase status", 32'he, {28'h0, d[7:4]});
		wr(4'h1, {9'h0, 15'h0040, 8'h00}); // lowest page of its block first
		op(3'h1, 2'h0);
		wr(4'h2, 32'h5a);
		op(3'h7, 2'h0);
		cmp("program byte", 32'h5a, {24'h0, dev.prog_data});
		op(3'h3, 2'h0); // refused while the execute is pending
		op(3'h1, 2'h0);
		rd(4'h3, d);
		cmp("program done", 32'h1, {31'h0, d[1]});
		op(3'h5, 2'h2);
		rd(4'h3, d);
		cmp("ready pin after reset", 32'h1, {31'h0, d[3]});
		rd(4'h0, d);
		cmp("region after reset", 32'h0, {30'h0, d[5:4]});
		read_at(15'h0001, 8'h02, 2'h0);
		rdbyte(px(15'h0001, 10'd2));
		results();
	end
endmodule // ncou_host_tb

bind ncou_host ncou_host_chk #(.PWR_WAIT(PWR_WAIT)) chk (.sys_clk, .reset, .reg_addr, .reg_rd,
	.reg_rdata, .chip_en_n, .cmd_latch, .addr_latch, .write_strobe_n, .output_strobe_n,
	.write_prot_n, .ready_busy_n, .io_out, .io_oe);
